// ### csi_core_state.sv
// CPU architectural state and interrupt entry logic
`timescale 1ns/1ps
// Behaviour
// - Negative flag at bit 2 follows result sign after each ALU operation.
// - Zero flag at bit 1 set on all-zero ALU result, else cleared.
// - Carry flag at bit 0 follows ALU carry out.
// - Register file offers byte and word read and write schemes.
// - Working registers also answer data addresses 0x00 to 0x1f.
// - Registers 26 to 31 pair into three pointers, low byte first.
// - Pointers serve with displacement, post-increment or pre-decrement.
// - Stack grows down; a data push lowers the pointer by one.
// - A data pop raises the stack pointer by one.
// - Calls and interrupt entry push return address, pointer minus two.
// - Returns pop the return address, stack pointer plus two.
// - Stack pointer is two readable writable bytes, resets to top.
// - Core runs straight from its clock with no division.
// - Two-operand ALU result is written back in one cycle.
// - A source is taken only when its enable and global enable are set.
// - Lowest vector wins; external request zero is the first source.
// - Relocation bit moves vectors; boot fuse moves reset vector.
// - Entry clears global enable; software may set it; return sets it.
// - Vectoring clears a flag source; writing one clears it too.
// - Flags raised while disabled stay pending until served or cleared.
// - Level sources request only while their condition is present.
// - At least two instructions run after return before the next interrupt.
// - Global disable acts at once, even on a same-cycle request.
// - Entry and return never save or restore the status register.
// - Boot lock settings may suppress interrupts by program region.
// - Sign bit equals negative xor overflow after each ALU update.
// - The instruction after global enable runs before any interrupt.
// - Interrupt response spans at least four cycles pushing the counter.
module csi_core_state #(
    parameter int NSRC = 8,
    parameter int PCW = 13,
    parameter logic [15:0] SP_RESET = csi_pkg::LAST_SRAM_ADDRESS,
    parameter logic [PCW-1:0] BOOT_START = '0
) (
    input wire logic clk,
    input wire logic sys_rst,
    // Instruction sequencer: ALU result
    input wire logic alu_valid,
    input wire logic [7:0] alu_result,
    input wire logic alu_carry,
    input wire logic alu_overflow,
    input wire logic alu_half,
    // Register file ports
    input wire logic [4:0] rd_a_idx,
    input wire logic [4:0] rd_b_idx,
    output logic [7:0] rd_a,
    output logic [7:0] rd_b,
    input wire logic wr_byte_en,
    input wire logic wr_word_en,
    input wire logic [4:0] wr_idx,
    input wire logic [15:0] wr_data,
    // Pointer access
    input wire logic ptr_req,
    input wire logic [1:0] ptr_sel,
    input wire logic [1:0] ptr_mode,
    input wire logic [5:0] ptr_disp,
    output logic [15:0] ptr_addr,
    // I/O register access
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [5:0] io_addr,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    // Stack
    input wire logic [2:0] stack_op,
    output logic [15:0] stack_pointer,
    // Instruction boundaries and global enable control
    input wire logic instr_done,
    input wire logic gie_set,
    input wire logic gie_clear,
    input wire logic [PCW-1:0] pc,
    // Interrupt sources
    input wire logic [NSRC-1:0] src_event,
    input wire logic [NSRC-1:0] src_level,
    input wire logic [NSRC-1:0] src_is_level,
    input wire logic [NSRC-1:0] src_enable,
    input wire logic [NSRC-1:0] flag_clear_w1,
    // Configuration
    input wire logic vector_relocate_bit,
    input wire logic boot_reset_vector_fuse,
    input wire logic app_boot_lock_bit,
    input wire logic boot_section_lock_bit,
    input wire logic [PCW-1:0] boot_region_start,
    // Interrupt entry toward the sequencer
    output logic irq_take,
    output logic [PCW-1:0] irq_vector,
    output logic irq_busy,
    output logic [7:0] result_status_register,
    output logic [NSRC-1:0] src_flag
);
    initial begin
        if (NSRC < 1 || NSRC > 32) $error("NSRC out of range");
        if (PCW < 8 || PCW > 16) $error("PCW out of range");
        if (csi_pkg::IRQ_RESP_CYC > 7) $error("response count too wide");
    end

    ////////////////////////////////////////////////////////////////////
    // Functions
    function automatic logic [15:0] sp_adjust(input logic [15:0] sp,
                                               input logic [2:0] op);
        case (op)
            csi_pkg::SOP_PUSH: sp_adjust = sp - csi_pkg::SP_STEP_BYTE;
            csi_pkg::SOP_POP: sp_adjust = sp + csi_pkg::SP_STEP_BYTE;
            csi_pkg::SOP_CALL: sp_adjust = sp - csi_pkg::SP_STEP_ADDR;
            csi_pkg::SOP_RET: sp_adjust = sp + csi_pkg::SP_STEP_ADDR;
            csi_pkg::SOP_INTERRUPT_RETURN_INSTR: sp_adjust = sp + csi_pkg::SP_STEP_ADDR;
            default: sp_adjust = sp;
        endcase
    endfunction

    function automatic logic [PCW-1:0] vec_addr(input int idx);
        vec_addr = PCW'(2 * idx);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Register file
    logic [15:0] ptr_x;
    logic [15:0] ptr_y;
    logic [15:0] ptr_z;
    logic [15:0] ptr_cur;
    logic [15:0] ptr_new;
    logic ptr_wb;
    logic [4:0] ptr_lo_idx;
    logic rf_lo_en;
    logic rf_hi_en;
    logic [4:0] rf_idx;
    logic [15:0] rf_data;

    // Pointer select and automatic update
    always_comb begin
        case (ptr_sel)
            2'h0: ptr_cur = ptr_x;
            2'h1: ptr_cur = ptr_y;
            default: ptr_cur = ptr_z;
        endcase
        case (ptr_sel)
            2'h0: ptr_lo_idx = csi_pkg::PTR_X_LO;
            2'h1: ptr_lo_idx = csi_pkg::PTR_Y_LO;
            default: ptr_lo_idx = csi_pkg::PTR_Z_LO;
        endcase
        case (ptr_mode)
            csi_pkg::PM_POSTINC: ptr_new = ptr_cur + 16'h0001;
            csi_pkg::PM_PREDEC: ptr_new = ptr_cur - 16'h0001;
            default: ptr_new = ptr_cur;
        endcase
        ptr_wb = ptr_req && (ptr_mode == csi_pkg::PM_POSTINC ||
            ptr_mode == csi_pkg::PM_PREDEC);
    end

    // Write port arbitration: sequencer write beats pointer update
    always_comb begin
        rf_lo_en = wr_byte_en || wr_word_en;
        rf_hi_en = wr_word_en;
        rf_idx = wr_idx;
        rf_data = wr_data;
        if (!(wr_byte_en || wr_word_en) && ptr_wb) begin
            rf_lo_en = 1'b1;
            rf_hi_en = 1'b1;
            rf_idx = ptr_lo_idx;
            rf_data = ptr_new;
        end
    end

    csi_regfile #(
        .NREG(csi_pkg::NUM_WREG)
    ) u_regfile (
        .clk(clk),
        .rd_a_idx(rd_a_idx),
        .rd_b_idx(rd_b_idx),
        .rd_a(rd_a),
        .rd_b(rd_b),
        .wr_lo_en(rf_lo_en),
        .wr_hi_en(rf_hi_en),
        .wr_idx(rf_idx),
        .wr_data(rf_data),
        .ptr_x(ptr_x),
        .ptr_y(ptr_y),
        .ptr_z(ptr_z)
    );

    // Effective data address; values below 0x20 reach the registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ptr_addr <= 16'h0000;
        end else if (ptr_req) begin
            case (ptr_mode)
                csi_pkg::PM_PREDEC: ptr_addr <= ptr_new;
                csi_pkg::PM_DISP: ptr_addr <= ptr_cur + {10'h000, ptr_disp};
                default: ptr_addr <= ptr_cur;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Status register
    logic neg_n;
    assign neg_n = alu_result[7];

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            result_status_register <= 8'h00;
        end else begin
            if (io_wr && io_addr == csi_pkg::OFS_STATUS) begin
                result_status_register <= io_wdata;
            end else if (alu_valid) begin
                result_status_register[csi_pkg::STAT_N] <= neg_n;
                result_status_register[csi_pkg::STAT_Z] <=
                    (alu_result == 8'h00);
                result_status_register[csi_pkg::STAT_C] <= alu_carry;
                result_status_register[csi_pkg::STAT_V] <= alu_overflow;
                result_status_register[csi_pkg::STAT_S] <=
                    neg_n ^ alu_overflow;
                result_status_register[csi_pkg::STAT_H] <= alu_half;
            end
            // Global enable: disable wins, entry clears, return sets
            if (gie_clear || irq_take) begin
                result_status_register[csi_pkg::STAT_I] <= 1'b0;
            end else if (gie_set || stack_op == csi_pkg::SOP_INTERRUPT_RETURN_INSTR) begin
                result_status_register[csi_pkg::STAT_I] <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Stack pointer
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stack_pointer <= SP_RESET;
        end else if (io_wr && io_addr == csi_pkg::OFS_SP_LOW) begin
            stack_pointer[7:0] <= io_wdata;
        end else if (io_wr && io_addr == csi_pkg::OFS_SP_HIGH) begin
            stack_pointer[15:8] <= io_wdata;
        end else if (irq_take) begin
            stack_pointer <= sp_adjust(stack_pointer,
                csi_pkg::SOP_CALL);
        end else begin
            stack_pointer <= sp_adjust(stack_pointer,
                stack_op);
        end
    end

    // Register read-back
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            io_rdata <= 8'h00;
        end else if (io_rd) begin
            case (io_addr)
                csi_pkg::OFS_SP_LOW: io_rdata <= stack_pointer[7:0];
                csi_pkg::OFS_SP_HIGH: io_rdata <= stack_pointer[15:8];
                csi_pkg::OFS_STATUS: io_rdata <= result_status_register;
                default: io_rdata <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Interrupt flags and arbitration
    logic [NSRC-1:0] req;
    logic [NSRC-1:0] grant;
    logic [NSRC-1:0] serve_clr;
    logic any_req;
    logic in_boot;
    logic lock_block;
    logic [PCW-1:0] win_vec;
    csi_pkg::csi_state_e state;
    logic [2:0] resp_cnt;
    logic take_now;
    logic [PCW-1:0] reset_vector;

    // Sticky flags: a new event wins over any clear
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            src_flag <= '0;
        end else begin
            src_flag <= (src_flag & ~(flag_clear_w1 | serve_clr))
                | src_event;
        end
    end

    // Boot lock suppression by program region
    assign in_boot = (pc >= boot_region_start);
    assign lock_block = (app_boot_lock_bit && !in_boot) ||
        (boot_section_lock_bit && in_boot);

    // Reset vector location, for the sequencer's restart fetch
    assign reset_vector = boot_reset_vector_fuse ? BOOT_START : '0;

    // Requests: flags or live levels, gated by own and global enables
    always_comb begin
        for (int i = 0; i < NSRC; i++) begin
            req[i] = src_enable[i] && (src_is_level[i] ? src_level[i]
                : src_flag[i]);
        end
        any_req = (|req) && result_status_register[csi_pkg::STAT_I]
            && !gie_clear && !gie_set && !lock_block;
        grant = '0;
        win_vec = '0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (req[i]) begin
                grant = '0;
                grant[i] = 1'b1;
                win_vec = vec_addr(i + 1);
            end
        end
        // Clear at the decision edge, so the flag matches the sent vector
        take_now = state == csi_pkg::ST_RUN && stack_op != csi_pkg::SOP_INTERRUPT_RETURN_INSTR
            && instr_done && any_req && !irq_take;
        serve_clr = take_now ? (grant & ~src_is_level) : '0;
    end

    // Entry, guard and exit sequencer on the undivided core clock
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= csi_pkg::ST_RUN;
            resp_cnt <= 3'h0;
            irq_take <= 1'b0;
            irq_busy <= 1'b0;
            irq_vector <= reset_vector;
        end else begin
            irq_take <= 1'b0;
            case (state)
                csi_pkg::ST_RUN: begin
                    if (stack_op == csi_pkg::SOP_INTERRUPT_RETURN_INSTR) begin
                        state <= csi_pkg::ST_GUARD;
                    end else if (take_now) begin
                        irq_take <= 1'b1;
                        irq_busy <= 1'b1;
                        irq_vector <= (vector_relocate_bit ? BOOT_START
                            : '0) + win_vec;
                        resp_cnt <= 3'(csi_pkg::IRQ_RESP_CYC);
                        state <= csi_pkg::ST_ENTRY;
                    end
                end
                csi_pkg::ST_ENTRY: begin
                    if (resp_cnt == 3'h1) begin
                        irq_busy <= 1'b0;
                        state <= csi_pkg::ST_RUN;
                    end
                    resp_cnt <= resp_cnt - 3'h1;
                end
                csi_pkg::ST_GUARD: begin
                    if (instr_done) begin
                        state <= csi_pkg::ST_EXIT;
                    end
                end
                csi_pkg::ST_EXIT: begin
                    if (instr_done) begin
                        state <= csi_pkg::ST_RUN;
                    end
                end
                default: state <= csi_pkg::ST_RUN;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    property p_zero_flag;
        @(posedge clk) disable iff (sys_rst)
        (alu_valid && !io_wr && alu_result == 8'h00)
            |=> result_status_register[csi_pkg::STAT_Z];
    endproperty
    a_zero_flag: assert property (p_zero_flag)
        else $error("zero flag not set");

    property p_sign;
        @(posedge clk) disable iff (sys_rst)
        $past(alu_valid && !io_wr) |-> result_status_register[csi_pkg::STAT_S]
            == (result_status_register[csi_pkg::STAT_N]
            ^ result_status_register[csi_pkg::STAT_V]);
    endproperty
    a_sign: assert property (p_sign)
        else $error("sign bit mismatch");

    property p_push;
        @(posedge clk) disable iff (sys_rst)
        (stack_op == csi_pkg::SOP_PUSH && !io_wr && !irq_take)
            |=> stack_pointer == $past(stack_pointer) - 16'h0001;
    endproperty
    a_push: assert property (p_push)
        else $error("push did not lower stack pointer");

    property p_ret;
        @(posedge clk) disable iff (sys_rst)
        (stack_op == csi_pkg::SOP_RET && !io_wr && !irq_take)
            |=> stack_pointer == $past(stack_pointer) + 16'h0002;
    endproperty
    a_ret: assert property (p_ret)
        else $error("return did not raise stack pointer");

    property p_cli_now;
        @(posedge clk) disable iff (sys_rst)
        gie_clear |=> !irq_take;
    endproperty
    a_cli_now: assert property (p_cli_now)
        else $error("interrupt taken after disable");

    property p_entry_clears_i;
        @(posedge clk) disable iff (sys_rst)
        irq_take |=> !result_status_register[csi_pkg::STAT_I];
    endproperty
    a_entry_clears_i: assert property (p_entry_clears_i)
        else $error("global enable not cleared on entry");

    sequence s_entry;
        irq_take ##1 irq_busy [*3];
    endsequence
    property p_resp_len;
        @(posedge clk) disable iff (sys_rst)
        irq_take |-> s_entry;
    endproperty
    a_resp_len: assert property (p_resp_len)
        else $error("entry shorter than four cycles");

    property p_gated;
        @(posedge clk) disable iff (sys_rst)
        $rose(irq_take) |-> $past(result_status_register[csi_pkg::STAT_I]);
    endproperty
    a_gated: assert property (p_gated)
        else $error("interrupt taken with global enable clear");

    property p_guard;
        @(posedge clk) disable iff (sys_rst)
        stack_op == csi_pkg::SOP_INTERRUPT_RETURN_INSTR |=> !irq_take ##1 !irq_take;
    endproperty
    a_guard: assert property (p_guard)
        else $error("interrupt served straight after return");
endmodule

// ### csi_pkg.sv
// Package of constants for the CPU state and interrupt entry block
package csi_pkg;
    // Status register bit positions
    localparam int STAT_C = 0;
    localparam int STAT_Z = 1;
    localparam int STAT_N = 2;
    localparam int STAT_V = 3;
    localparam int STAT_S = 4;
    localparam int STAT_H = 5;
    localparam int STAT_T = 6;
    localparam int STAT_I = 7;
    // I/O offsets of the stack pointer bytes and status register
    localparam logic [5:0] OFS_SP_LOW = 6'h3d;
    localparam logic [5:0] OFS_SP_HIGH = 6'h3e;
    localparam logic [5:0] OFS_STATUS = 6'h3f;
    // Working register file
    localparam int NUM_WREG = 32;
    localparam logic [4:0] PTR_X_LO = 5'h1a;
    localparam logic [4:0] PTR_Y_LO = 5'h1c;
    localparam logic [4:0] PTR_Z_LO = 5'h1e;
    // Reset value of the stack pointer: last internal data address
    localparam logic [15:0] LAST_SRAM_ADDRESS = 16'h04ff;
    // Stack adjustments
    localparam logic [15:0] SP_STEP_BYTE = 16'h0001;
    localparam logic [15:0] SP_STEP_ADDR = 16'h0002;
    // Interrupt response time
    localparam int IRQ_RESP_NS = 100;
    localparam int CLK_PERIOD_NS = 25;
    localparam int IRQ_RESP_CYC = (IRQ_RESP_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    // Stack operations
    localparam logic [2:0] SOP_NONE = 3'h0;
    localparam logic [2:0] SOP_PUSH = 3'h1;
    localparam logic [2:0] SOP_POP = 3'h2;
    localparam logic [2:0] SOP_CALL = 3'h3;
    localparam logic [2:0] SOP_RET = 3'h4;
    localparam logic [2:0] SOP_INTERRUPT_RETURN_INSTR = 3'h5;
    // Pointer access modes
    localparam logic [1:0] PM_PLAIN = 2'h0;
    localparam logic [1:0] PM_POSTINC = 2'h1;
    localparam logic [1:0] PM_PREDEC = 2'h2;
    localparam logic [1:0] PM_DISP = 2'h3;
    // Interrupt sequencer states
    typedef enum logic [3:0] {
        ST_RUN = 4'h1,
        ST_ENTRY = 4'h2,
        ST_GUARD = 4'h4,
        ST_EXIT = 4'h8
    } csi_state_e;
endpackage

// ### csi_regfile.sv
// Working register file with two byte read ports and a 16-bit write
`timescale 1ns/1ps
module csi_regfile #(
    parameter int NREG = 32
) (
    input wire logic clk,
    input wire logic [4:0] rd_a_idx,
    input wire logic [4:0] rd_b_idx,
    output logic [7:0] rd_a,
    output logic [7:0] rd_b,
    input wire logic wr_lo_en,
    input wire logic wr_hi_en,
    input wire logic [4:0] wr_idx,
    input wire logic [15:0] wr_data,
    output logic [15:0] ptr_x,
    output logic [15:0] ptr_y,
    output logic [15:0] ptr_z
);
    logic [7:0] mem [NREG];

    initial begin
        if (NREG != 32) $error("register file must hold 32 bytes");
    end

    // Byte write to the low index, high byte to the odd partner
    always_ff @(posedge clk) begin
        if (wr_lo_en) begin
            mem[wr_idx] <= wr_data[7:0];
        end
        if (wr_hi_en) begin
            mem[{wr_idx[4:1], 1'b1}] <= wr_data[15:8];
        end
    end

    // Registered read ports
    always_ff @(posedge clk) begin
        rd_a <= mem[rd_a_idx];
        rd_b <= mem[rd_b_idx];
    end

    // Pointer pairs, low byte in the lower register
    assign ptr_x = {mem[csi_pkg::PTR_X_LO + 5'h01], mem[csi_pkg::PTR_X_LO]};
    assign ptr_y = {mem[csi_pkg::PTR_Y_LO + 5'h01], mem[csi_pkg::PTR_Y_LO]};
    assign ptr_z = {mem[csi_pkg::PTR_Z_LO + 5'h01], mem[csi_pkg::PTR_Z_LO]};
endmodule

// ### csi_src_model.sv
// Peripheral interrupt source model driving event and level requests
`timescale 1ns/1ps
module csi_src_model #(
    parameter int NSRC = 8
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic fire,
    input wire logic [2:0] fire_idx,
    input wire logic [NSRC-1:0] level_set,
    output logic [NSRC-1:0] src_event,
    output logic [NSRC-1:0] src_level
);
    // One-cycle event pulse for each request from the bench
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            src_event <= '0;
        end else begin
            src_event <= '0;
            if (fire) begin
                src_event[fire_idx] <= 1'b1;
            end
        end
    end
    // Level conditions stay up only while the bench holds them
    assign src_level = level_set;
endmodule

// ### tb.sv
// Self-checking testbench for the CPU state and interrupt entry block
`timescale 1ns/1ps
module tb;
    logic clk, sys_rst, alu_valid, alu_carry, alu_overflow, alu_half;
    logic [7:0] alu_result, rd_a, rd_b, io_wdata, io_rdata, status;
    logic [4:0] rd_a_idx, rd_b_idx, wr_idx;
    logic wr_byte_en, wr_word_en, ptr_req, io_wr, io_rd;
    logic [15:0] wr_data, ptr_addr, sp;
    logic [1:0] ptr_sel, ptr_mode;
    logic [5:0] ptr_disp, io_addr;
    logic [2:0] stack_op, fire_idx;
    logic instr_done, gie_set, gie_clear, fire, vrel, irq_take, irq_busy;
    logic [12:0] irq_vector;
    logic [7:0] src_event, src_level, src_is_level, src_enable, clr_w1;
    logic [7:0] level_set, src_flag;
    int n_mismatch, total_checks, n_cyc;

    csi_src_model i_csi_src_model (.clk(clk), .sys_rst(sys_rst),
        .fire(fire), .fire_idx(fire_idx), .level_set(level_set),
        .src_event(src_event), .src_level(src_level));

    csi_core_state #(.BOOT_START(13'h0c00)) i_csi_core_state (.clk(clk),
        .sys_rst(sys_rst),
        .alu_valid(alu_valid), .alu_result(alu_result),
        .alu_carry(alu_carry), .alu_overflow(alu_overflow),
        .alu_half(alu_half), .rd_a_idx(rd_a_idx), .rd_b_idx(rd_b_idx),
        .rd_a(rd_a), .rd_b(rd_b), .wr_byte_en(wr_byte_en),
        .wr_word_en(wr_word_en), .wr_idx(wr_idx), .wr_data(wr_data),
        .ptr_req(ptr_req), .ptr_sel(ptr_sel), .ptr_mode(ptr_mode),
        .ptr_disp(ptr_disp), .ptr_addr(ptr_addr), .io_wr(io_wr),
        .io_rd(io_rd), .io_addr(io_addr), .io_wdata(io_wdata),
        .io_rdata(io_rdata), .stack_op(stack_op), .stack_pointer(sp),
        .instr_done(instr_done), .gie_set(gie_set), .gie_clear(gie_clear),
        .pc(13'h0000), .src_event(src_event), .src_level(src_level),
        .src_is_level(src_is_level), .src_enable(src_enable),
        .flag_clear_w1(clr_w1), .vector_relocate_bit(vrel),
        .boot_reset_vector_fuse(1'b1), .app_boot_lock_bit(1'b0),
        .boot_section_lock_bit(1'b0), .boot_region_start(13'h1000),
        .irq_take(irq_take), .irq_vector(irq_vector), .irq_busy(irq_busy),
        .result_status_register(status), .src_flag(src_flag));

    // Clock at 40 MHz
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Ends the run with counts and verdict
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // Cuts a hang short
    always @(posedge clk) begin
        n_cyc++;
        if (n_cyc == 3000) begin
            n_mismatch++;
            complete_run();
        end
    end

    task automatic tick();
        @(negedge clk);
    endtask

    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s exp %h got %h", what, exp, got);
        end
    endtask

    // Register bus write or read, one pulse, data answered next edge
    task automatic io(input logic wr, input logic [5:0] a,
                      input logic [7:0] d, input logic [7:0] exp);
        io_wr = wr;
        io_rd = !wr;
        io_addr = a;
        io_wdata = d;
        tick();
        io_wr = 1'b0;
        io_rd = 1'b0;
        if (!wr) chk("io_rdata", {8'h00, exp}, {8'h00, io_rdata});
    endtask

    // One-cycle stack operation, pointer checked after the edge
    task automatic stk(input logic [2:0] op, input logic [15:0] exp);
        stack_op = op;
        tick();
        stack_op = csi_pkg::SOP_NONE;
        chk("stack_pointer", exp, sp);
    endtask

    task automatic pulse(ref logic s);
        s = 1'b1;
        tick();
        s = 1'b0;
    endtask

    initial begin
        {alu_valid, alu_carry, alu_overflow, alu_half, wr_byte_en} = '0;
        {wr_word_en, ptr_req, io_wr, io_rd, instr_done, gie_set} = '0;
        {gie_clear, fire, vrel, alu_result, rd_a_idx, rd_b_idx} = '0;
        {wr_idx, wr_data, ptr_sel, ptr_mode, ptr_disp, io_addr} = '0;
        {io_wdata, stack_op, fire_idx, src_is_level, clr_w1} = '0;
        {src_enable, level_set} = '0;
        sys_rst = 1'b1;
        repeat (4) tick();
        sys_rst = 1'b0;
        chk("irq_vector", 16'h0c00, {3'h0, irq_vector});
        io(1'b0, 6'h3d, 8'h00, 8'hff);
        io(1'b0, 6'h3e, 8'h00, 8'h04);
        io(1'b0, 6'h10, 8'h00, 8'h00);
        io(1'b1, 6'h3d, 8'h80, 8'h00);
        io(1'b1, 6'h3e, 8'h02, 8'h00);
        chk("stack_pointer", 16'h0280, sp);
        stk(csi_pkg::SOP_PUSH, 16'h027f);
        stk(csi_pkg::SOP_POP, 16'h0280);
        stk(csi_pkg::SOP_CALL, 16'h027e);
        stk(csi_pkg::SOP_RET, 16'h0280);
        $display("test io and stack done");
        alu_valid = 1'b1;
        alu_result = 8'h80;
        tick();
        alu_result = 8'h00;
        alu_carry = 1'b1;
        alu_overflow = 1'b1;
        chk("status", 16'h0014, {11'h000, status[4:0]});
        tick();
        alu_valid = 1'b0;
        chk("status", 16'h001b, {11'h000, status[4:0]});
        tick();
        chk("status", 16'h001b, {11'h000, status[4:0]});
        $display("test flags done");
        wr_idx = csi_pkg::PTR_X_LO;
        wr_data = 16'h1234;
        pulse(wr_word_en);
        ptr_req = 1'b1;
        rd_a_idx = 5'h1a;
        rd_b_idx = 5'h1b;
        tick();
        ptr_req = 1'b0;
        chk("ptr_addr", 16'h1234, ptr_addr);
        chk("rd_pair", 16'h1234, {rd_b, rd_a});
        ptr_mode = csi_pkg::PM_POSTINC;
        pulse(ptr_req);
        chk("ptr_addr", 16'h1234, ptr_addr);
        ptr_mode = csi_pkg::PM_PREDEC;
        pulse(ptr_req);
        chk("ptr_addr", 16'h1234, ptr_addr);
        ptr_mode = csi_pkg::PM_DISP;
        ptr_disp = 6'h05;
        pulse(ptr_req);
        chk("ptr_addr", 16'h1239, ptr_addr);
        $display("test pointer done");
        src_enable = 8'h02;
        fire_idx = 3'h1;
        pulse(fire);
        tick();
        pulse(instr_done);
        chk("irq_take", 16'h0000, {15'h0, irq_take});
        chk("src_flag", 16'h0002, {8'h00, src_flag});
        pulse(gie_set);
        pulse(instr_done);
        chk("irq_take", 16'h0001, {15'h0, irq_take});
        chk("irq_vector", 16'h0004, {3'h0, irq_vector});
        chk("irq_busy", 16'h0001, {15'h0, irq_busy});
        tick();
        chk("stack_pointer", 16'h027e, sp);
        chk("gie", 16'h0000, {15'h0, status[7]});
        chk("src_flag", 16'h0000, {8'h00, src_flag});
        repeat (2) tick();
        chk("irq_busy", 16'h0001, {15'h0, irq_busy});
        tick();
        chk("irq_busy", 16'h0000, {15'h0, irq_busy});
        tick();
        stk(csi_pkg::SOP_INTERRUPT_RETURN_INSTR, 16'h0280);
        tick();
        chk("gie", 16'h0001, {15'h0, status[7]});
        $display("test interrupt done");
        vrel = 1'b1;
        src_enable = 8'h03;
        src_is_level = 8'h01;
        level_set = 8'h01;
        pulse(fire);
        tick();
        pulse(instr_done);
        chk("irq_take", 16'h0000, {15'h0, irq_take});
        pulse(instr_done);
        chk("irq_take", 16'h0000, {15'h0, irq_take});
        pulse(instr_done);
        chk("irq_vector", 16'h0c02, {3'h0, irq_vector});
        tick();
        chk("src_flag", 16'h0002, {8'h00, src_flag});
        level_set = 8'h00;
        repeat (4) tick();
        pulse(gie_set);
        {instr_done, gie_clear} = 2'b11;
        tick();
        {instr_done, gie_clear} = 2'b00;
        chk("irq_take", 16'h0000, {15'h0, irq_take});
        clr_w1 = 8'h02;
        tick();
        clr_w1 = 8'h00;
        chk("src_flag", 16'h0000, {8'h00, src_flag});
        $display("test priority and disable done");
        complete_run();
    end
endmodule
